//--- rtl/rsp_device.sv
// relay end: status word, switch report, run arbitration, serial packet server
// assumes protection logic on the same clock; hard-wired pins and rx are asynchronous
`timescale 1ns/1ns
module rsp_device
  import rsp_pkg::*;
#(
  parameter logic [15:0] BIT_CYCLES = BIT_CYCLES_DEF
) (
  input  wire logic        clock,
  input  wire logic        srst,
  rsp_link_if.dev          link,
  input  wire logic        stop_input,
  input  wire logic        reset_input,
  input  wire logic        run_one_input,
  input  wire logic        run_two_input,
  input  wire logic        aux_input_one,
  input  wire logic        aux_input_two,
  input  wire logic        network_control_input,
  input  wire logic [7:0]  node_switch,
  input  wire logic        login_above_user,
  input  wire logic        fault_active,
  input  wire logic        warning_active,
  input  wire logic [3:0]  fault_cause,
  input  wire logic        motor_hot,
  input  wire logic [7:0]  cooldown_time,
  input  wire logic        net_active,
  input  wire logic        net_run_one,
  input  wire logic        net_run_two,
  input  wire logic        net_stop,
  input  wire logic        expl_valid,
  input  wire logic [7:0]  expl_service,
  input  wire logic [7:0]  expl_class,
  input  wire logic [7:0]  expl_instance,
  input  wire logic [7:0]  expl_attribute,
  output logic             run_one_cmd,
  output logic             run_two_cmd,
  output logic [15:0]      status_word,
  output logic             status_change,
  output logic [15:0]      switch_word,
  output logic [15:0]      cooldown_word,
  output logic             expl_rsp_valid,
  output logic [7:0]       expl_rsp_service,
  output logic [7:0]       response_low_byte,
  output logic [7:0]       response_high_byte
);
  localparam logic [15:0] HALF_BIT = BIT_CYCLES >> 1;

  logic [15:0] pin_raw, pin_a, pin_b, pin_c, pins, pins_d;
  rsp_rx_t     rx_st;
  logic [15:0] rx_cnt, tx_cnt;
  logic [3:0]  rx_bit, pkt_cnt, tx_bitn, tx_left;
  logic [7:0]  rx_sh;
  logic        rx_stb, pkt_done, tx_line;
  logic [63:0] pkt, tx_pkt, rsp_frame;
  logic [9:0]  tx_fr;
  logic        pkt_ok, ser_set, ser_stop, ser_run_one_input, ser_run_two_input, net_ctrl, running;
  logic        hard_stop, cmd_stop, ctl_drop, net_drop, net_last_stop, hot_at_trip, fault_d, fault_any;
  logic [16:0] ser_rd, expl_rd;
  logic [55:0] rsp_head;
  logic [15:0] next_status;
  logic [3:0]  cause;

  assign pin_raw = {node_switch, link.req_line, network_control_input, aux_input_two, aux_input_one,
                    run_two_input, run_one_input, reset_input, stop_input};

  // three-stage capture of every asynchronous pin
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_a <= PIN_IDLE;
      pin_b <= PIN_IDLE;
      pin_c <= PIN_IDLE;
    end else begin
      pin_a <= pin_raw;
      pin_b <= pin_a;
      pin_c <= pin_b;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge clock) begin
    if (srst) begin
      pins   <= PIN_IDLE;
      pins_d <= PIN_IDLE;
    end else begin
      pins   <= (pin_b & ~(pin_b ^ pin_c)) | (pins & (pin_b ^ pin_c));
      pins_d <= pins;
    end
  end

  // receiver, samples mid-bit, drops framing errors
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_st  <= RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_sh  <= 8'h00;
      rx_stb <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      if (rx_cnt != 16'h0000) rx_cnt <= rx_cnt - 16'h0001;
      unique case (rx_st)
        RX_IDLE: if (!pins[PIN_RX]) begin
          rx_st  <= RX_START;
          rx_cnt <= HALF_BIT;
        end
        RX_START: if (rx_cnt == 16'h0000) begin
          rx_st  <= pins[PIN_RX] ? RX_IDLE : RX_DATA;
          rx_cnt <= BIT_CYCLES - 16'h0001;
          rx_bit <= 4'h0;
        end
        RX_DATA: if (rx_cnt == 16'h0000) begin
          rx_sh  <= {pins[PIN_RX], rx_sh[7:1]};
          rx_bit <= rx_bit + 4'h1;
          rx_cnt <= BIT_CYCLES - 16'h0001;
          if (rx_bit == 4'h7) rx_st <= RX_STOP;
        end
        RX_STOP: if (rx_cnt == 16'h0000) begin
          rx_st  <= RX_IDLE;
          rx_stb <= pins[PIN_RX];
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // packet assembly, waits for the start byte
  always_ff @(posedge clock) begin
    if (srst) begin
      pkt      <= 64'h0000000000000000;
      pkt_cnt  <= 4'h0;
      pkt_done <= 1'b0;
    end else begin
      pkt_done <= 1'b0;
      if (rx_stb && (pkt_cnt != 4'h0 || rx_sh == SOH)) begin
        pkt <= {pkt[55:0], rx_sh};
        if (pkt_cnt == PKT_LEN - 4'h1) begin
          pkt_cnt  <= 4'h0;
          pkt_done <= 1'b1;
        end else begin
          pkt_cnt <= pkt_cnt + 4'h1;
        end
      end
    end
  end

  // request decode; a bad sum means no action and no reply
  assign pkt_ok   = pkt_done && (rsp_sum(pkt) == 8'h00);
  assign ser_set  = pkt_ok && pkt[55:48] == SVC_SET && pkt[47:40] == ATTR_RUN;
  assign ser_stop = ser_set && pkt[8 + RUN_STOP_BIT];
  assign ser_run_one_input = ser_set && pkt[8 + RUN_ONE_BIT];
  assign ser_run_two_input = ser_set && pkt[8 + RUN_TWO_BIT];
  assign ser_rd   = rsp_read_attr(pkt[47:40], status_word, switch_word, cooldown_word);

  // reply frame, data most significant byte first
  always_comb begin
    if (pkt[55:48] == SVC_GET && ser_rd[16]) begin
      rsp_head = {SOH, SVC_GET | SVC_REPLY, pkt[47:40], 16'h0000, ser_rd[15:0]};
    end else if (pkt[55:48] == SVC_SET && pkt[47:40] == ATTR_RUN) begin
      rsp_head = {SOH, SVC_SET | SVC_REPLY, pkt[47:8]};
    end else begin
      rsp_head = {SOH, SVC_ERROR, pkt[47:40], 32'h00000000};
    end
  end
  assign rsp_frame = rsp_seal(rsp_head);

  // transmitter; a request arriving mid-reply gets no reply, though its run or stop is still obeyed, no queue kept
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_cnt  <= 16'h0000;
      tx_bitn <= 4'h0;
      tx_left <= 4'h0;
      tx_fr   <= 10'h3FF;
      tx_pkt  <= 64'h0000000000000000;
      tx_line <= 1'b1;
    end else if (tx_cnt != 16'h0000) begin
      tx_cnt <= tx_cnt - 16'h0001;
    end else if (tx_bitn != 4'h0) begin
      tx_line <= tx_fr[0];
      tx_fr   <= {1'b1, tx_fr[9:1]};
      tx_bitn <= tx_bitn - 4'h1;
      tx_cnt  <= BIT_CYCLES - 16'h0001;
    end else if (tx_left != 4'h0) begin
      tx_fr   <= {1'b1, tx_pkt[63:56], 1'b0};
      tx_pkt  <= {tx_pkt[55:0], 8'h00};
      tx_left <= tx_left - 4'h1;
      tx_bitn <= FRAME_BITS;
    end else if (pkt_ok) begin
      tx_pkt  <= rsp_frame;
      tx_left <= PKT_LEN;
    end
  end
  assign link.rsp_line = tx_line;

  // run arbitration
  assign net_ctrl  = pins[SW_NETCTRL];
  assign running   = run_one_cmd | run_two_cmd;
  assign hard_stop = pins[SW_STOP] | fault_active;
  assign cmd_stop  = net_stop | ser_stop;
  assign ctl_drop  = pins_d[SW_NETCTRL] & ~net_ctrl & running;
  always_ff @(posedge clock) begin
    if (srst) begin
      run_one_cmd   <= 1'b0;
      run_two_cmd   <= 1'b0;
      net_last_stop <= 1'b0;
    end else if (hard_stop || ctl_drop) begin
      run_one_cmd <= 1'b0;
      run_two_cmd <= 1'b0;
      if (running) net_last_stop <= 1'b0;
    end else if (cmd_stop) begin
      run_one_cmd <= 1'b0;
      run_two_cmd <= 1'b0;
      if (running) net_last_stop <= 1'b1;
    end else if (net_ctrl) begin
      if (net_run_one || ser_run_one_input) begin
        run_one_cmd <= 1'b1;
        run_two_cmd <= 1'b0;
      end else if (net_run_two || ser_run_two_input) begin
        run_one_cmd <= 1'b0;
        run_two_cmd <= 1'b1;
      end
    end else if (pins[SW_RUN_ONE_INPUT] && !pins_d[SW_RUN_ONE_INPUT]) begin
      run_one_cmd <= 1'b1;
      run_two_cmd <= 1'b0;
    end else if (pins[SW_RUN_TWO_INPUT] && !pins_d[SW_RUN_TWO_INPUT]) begin
      run_one_cmd <= 1'b0;
      run_two_cmd <= 1'b1;
    end
  end

  // network-loss trip, cleared by the reset input; a new drop wins
  always_ff @(posedge clock) begin
    if (srst) begin
      net_drop <= 1'b0;
    end else if (ctl_drop) begin
      net_drop <= 1'b1;
    end else if (pins[SW_RESET] && !pins_d[SW_RESET]) begin
      net_drop <= 1'b0;
    end
  end

  // hot flag caught on the trip edge, held while the fault stands
  assign fault_any = fault_active | net_drop;
  always_ff @(posedge clock) begin
    if (srst) begin
      fault_d     <= 1'b0;
      hot_at_trip <= 1'b0;
    end else begin
      fault_d <= fault_any;
      if (fault_any && !fault_d) hot_at_trip <= motor_hot;
      else if (!fault_any) hot_at_trip <= 1'b0;
    end
  end

  // status word assembly
  assign cause = fault_active ? fault_cause : (net_drop ? CAUSE_NETWORK : CAUSE_NONE);
  always_comb begin
    next_status                    = 16'h0000;
    next_status[ST_FAULT]          = fault_any;
    next_status[ST_WARN]           = warning_active;
    next_status[ST_RUN_ONE_INPUT]           = run_one_cmd;
    next_status[ST_RUN_TWO_INPUT]           = run_two_cmd;
    next_status[ST_NETCTRL]        = net_ctrl;
    next_status[ST_NETACT]         = net_active;
    next_status[ST_NETSTOP]        = net_last_stop;
    next_status[ST_CAUSE +: 4]     = cause;
    next_status[ST_LOGIN]          = login_above_user;
    next_status[ST_HOT]            = hot_at_trip;
  end

  // registered words; change pulse feeds change-of-state traffic
  always_ff @(posedge clock) begin
    if (srst) begin
      status_word   <= 16'h0000;
      status_change <= 1'b0;
      switch_word   <= 16'h0000;
      cooldown_word <= 16'h0000;
    end else begin
      status_word   <= next_status;
      status_change <= next_status != status_word;
      switch_word   <= {pins[15:8], 1'b0, pins[6:0]};
      cooldown_word <= {8'h00, (cooldown_time > COOL_MAX) ? COOL_MAX : cooldown_time};
    end
  end

  // explicit read from the network side
  assign expl_rd = rsp_read_attr(expl_attribute, status_word, switch_word, cooldown_word);
  always_ff @(posedge clock) begin
    if (srst) begin
      expl_rsp_valid     <= 1'b0;
      expl_rsp_service   <= 8'h00;
      response_low_byte  <= 8'h00;
      response_high_byte <= 8'h00;
    end else begin
      expl_rsp_valid <= expl_valid;
      if (expl_valid) begin
        if (expl_service == SVC_GET && expl_class == EXT_CLASS && expl_instance == EXT_INST && expl_rd[16]) begin
          expl_rsp_service   <= SVC_GET | SVC_REPLY;
          response_low_byte  <= expl_rd[7:0];
          response_high_byte <= expl_rd[15:8];
        end else begin
          expl_rsp_service   <= SVC_ERROR;
          response_low_byte  <= 8'h00;
          response_high_byte <= 8'h00;
        end
      end
    end
  end
endmodule // rsp_device

//--- rtl/rsp_pkg.sv
// package of the relay status and serial packet port: constants, codes, helpers
// assumes a 100 MHz system clock shared by both ends of the serial link
package rsp_pkg;
  // serial timing
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned BAUD_RATE      = 19200;
  localparam logic [15:0] BIT_CYCLES_DEF = 16'(CLK_HZ / BAUD_RATE);
  localparam logic [3:0]  PKT_LEN        = 4'h8;
  localparam logic [3:0]  FRAME_BITS     = 4'hA;
  // packet codes
  localparam logic [7:0]  SOH            = 8'h01;
  localparam logic [7:0]  SVC_GET        = 8'h0E;
  localparam logic [7:0]  SVC_SET        = 8'h10;
  localparam logic [7:0]  SVC_REPLY      = 8'h80;
  localparam logic [7:0]  SVC_ERROR      = 8'h94;
  localparam logic [7:0]  EXT_CLASS      = 8'h64;
  localparam logic [7:0]  EXT_INST       = 8'h01;
  localparam logic [7:0]  ATTR_STATUS    = 8'h20;
  localparam logic [7:0]  ATTR_RUN       = 8'h21;
  localparam logic [7:0]  ATTR_SWITCH    = 8'h34;
  localparam logic [7:0]  ATTR_COOL      = 8'h38;
  // run command bits in data 0
  localparam int unsigned RUN_ONE_BIT    = 0;
  localparam int unsigned RUN_TWO_BIT    = 1;
  localparam int unsigned RUN_STOP_BIT   = 2;
  // status word bits, cause nibble at 11:8
  localparam int unsigned ST_FAULT       = 0;
  localparam int unsigned ST_WARN        = 1;
  localparam int unsigned ST_RUN_ONE_INPUT        = 2;
  localparam int unsigned ST_RUN_TWO_INPUT        = 3;
  localparam int unsigned ST_NETCTRL     = 5;
  localparam int unsigned ST_NETACT      = 6;
  localparam int unsigned ST_NETSTOP     = 7;
  localparam int unsigned ST_CAUSE       = 8;
  localparam int unsigned ST_LOGIN       = 14;
  localparam int unsigned ST_HOT         = 15;
  // fault cause codes
  localparam logic [3:0]  CAUSE_NONE     = 4'h0;
  localparam logic [3:0]  CAUSE_OVERCUR  = 4'h1;
  localparam logic [3:0]  CAUSE_GROUND   = 4'h2;
  localparam logic [3:0]  CAUSE_JAM      = 4'h3;
  localparam logic [3:0]  CAUSE_STALL    = 4'h4;
  localparam logic [3:0]  CAUSE_UNBAL    = 4'h5;
  localparam logic [3:0]  CAUSE_AUX      = 4'h6;
  localparam logic [3:0]  CAUSE_LOADLOSS = 4'h7;
  localparam logic [3:0]  CAUSE_NETWORK  = 4'hA;
  localparam logic [3:0]  CAUSE_VOLTAGE  = 4'hB;
  // switch byte bits
  localparam int unsigned SW_STOP        = 0;
  localparam int unsigned SW_RESET       = 1;
  localparam int unsigned SW_RUN_ONE_INPUT        = 2;
  localparam int unsigned SW_RUN_TWO_INPUT        = 3;
  localparam int unsigned SW_AUX1        = 4;
  localparam int unsigned SW_AUX2        = 5;
  localparam int unsigned SW_NETCTRL     = 6;
  localparam int unsigned PIN_RX         = 7;
  localparam logic [15:0] PIN_IDLE       = 16'h0080;
  localparam logic [7:0]  COOL_MAX       = 8'h63;
  // host register byte offsets and fields
  localparam logic [7:0]  REG_REQ_HEAD   = 8'h00;
  localparam logic [7:0]  REG_REQ_DATA   = 8'h04;
  localparam logic [7:0]  REG_CTRL       = 8'h08;
  localparam logic [7:0]  REG_STAT       = 8'h0C;
  localparam logic [7:0]  REG_RSP_HEAD   = 8'h10;
  localparam logic [7:0]  REG_RSP_DATA   = 8'h14;
  localparam int unsigned CTRL_SEND      = 0;
  localparam int unsigned STAT_BUSY      = 0;
  localparam int unsigned STAT_READY     = 1;
  localparam int unsigned STAT_BADSUM    = 2;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rsp_rx_t;

  // byte sum of a packet, first byte in bits 63:56
  function automatic logic [7:0] rsp_sum(input logic [63:0] p);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) s = s + p[i*8 +: 8];
    return s;
  endfunction

  // append the two's complement checksum to seven bytes
  function automatic logic [63:0] rsp_seal(input logic [55:0] head);
    logic [7:0] s;
    s = rsp_sum({head, 8'h00});
    return {head, ~s + 8'h01};
  endfunction

  // readable attribute lookup; bit 16 flags a known attribute
  function automatic logic [16:0] rsp_read_attr(input logic [7:0] attr, input logic [15:0] st,
                                                input logic [15:0] sw, input logic [15:0] cd);
    case (attr)
      ATTR_STATUS: return {1'b1, st};
      ATTR_SWITCH: return {1'b1, sw};
      ATTR_COOL:   return {1'b1, cd};
      default:     return 17'h00000;
    endcase
  endfunction
endpackage

//--- rtl/rsp_link_if.sv
// serial link between the handheld or host end and the relay end
// both lines idle high; 19200 8N1 framing, both ends on one clock
`timescale 1ns/1ns
interface rsp_link_if;
  logic req_line;
  logic rsp_line;
  modport dev (input req_line, output rsp_line);
  modport host (output req_line, input rsp_line);
endinterface

//--- rtl/rsp_host.sv
// host end: sends one eight-byte request, collects the eight-byte reply
// assumes software on a plain register port; reply line is asynchronous
`timescale 1ns/1ns
module rsp_host
  import rsp_pkg::*;
#(
  parameter logic [15:0] BIT_CYCLES = BIT_CYCLES_DEF
) (
  input  wire logic        clock,
  input  wire logic        srst,
  rsp_link_if.host         link,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);
  localparam logic [15:0] HALF_BIT = BIT_CYCLES >> 1;

  logic        ln_a, ln_b, ln_c, rx_lvl, rx_stb, pkt_done, tx_line, busy, send;
  rsp_rx_t     rx_st;
  logic [15:0] rx_cnt, tx_cnt, req_head, rsp_head;
  logic [3:0]  rx_bit, pkt_cnt, tx_bitn, tx_left;
  logic [7:0]  rx_sh;
  logic [63:0] pkt, tx_pkt;
  logic [9:0]  tx_fr;
  logic [31:0] req_data, rsp_data;
  logic        rsp_ready, bad_sum;

  // three-stage capture of the reply line
  always_ff @(posedge clock) begin
    if (srst) begin
      ln_a   <= 1'b1;
      ln_b   <= 1'b1;
      ln_c   <= 1'b1;
      rx_lvl <= 1'b1;
    end else begin
      ln_a <= link.rsp_line;
      ln_b <= ln_a;
      ln_c <= ln_b;
      if (ln_b == ln_c) rx_lvl <= ln_c;
    end
  end

  // receiver, same framing as the relay end
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_st  <= RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_sh  <= 8'h00;
      rx_stb <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      if (rx_cnt != 16'h0000) rx_cnt <= rx_cnt - 16'h0001;
      unique case (rx_st)
        RX_IDLE: if (!rx_lvl) begin
          rx_st  <= RX_START;
          rx_cnt <= HALF_BIT;
        end
        RX_START: if (rx_cnt == 16'h0000) begin
          rx_st  <= rx_lvl ? RX_IDLE : RX_DATA;
          rx_cnt <= BIT_CYCLES - 16'h0001;
          rx_bit <= 4'h0;
        end
        RX_DATA: if (rx_cnt == 16'h0000) begin
          rx_sh  <= {rx_lvl, rx_sh[7:1]};
          rx_bit <= rx_bit + 4'h1;
          rx_cnt <= BIT_CYCLES - 16'h0001;
          if (rx_bit == 4'h7) rx_st <= RX_STOP;
        end
        RX_STOP: if (rx_cnt == 16'h0000) begin
          rx_st  <= RX_IDLE;
          rx_stb <= rx_lvl;
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // reply assembly from the start byte
  always_ff @(posedge clock) begin
    if (srst) begin
      pkt      <= 64'h0000000000000000;
      pkt_cnt  <= 4'h0;
      pkt_done <= 1'b0;
    end else begin
      pkt_done <= 1'b0;
      if (rx_stb && (pkt_cnt != 4'h0 || rx_sh == SOH)) begin
        pkt <= {pkt[55:0], rx_sh};
        if (pkt_cnt == PKT_LEN - 4'h1) begin
          pkt_cnt  <= 4'h0;
          pkt_done <= 1'b1;
        end else begin
          pkt_cnt <= pkt_cnt + 4'h1;
        end
      end
    end
  end

  // software registers; hardware set beats a write-one clear
  assign send = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_SEND] && !busy;
  always_ff @(posedge clock) begin
    if (srst) begin
      req_head  <= 16'h0000;
      req_data  <= 32'h00000000;
      rsp_head  <= 16'h0000;
      rsp_data  <= 32'h00000000;
      rsp_ready <= 1'b0;
      bad_sum   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == REG_REQ_HEAD) req_head <= reg_wdata[15:0];
      if (reg_wr && reg_addr == REG_REQ_DATA) req_data <= reg_wdata;
      if (reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_READY]) rsp_ready <= 1'b0;
      if (reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_BADSUM]) bad_sum <= 1'b0;
      if (pkt_done && rsp_sum(pkt) == 8'h00) begin
        rsp_head  <= pkt[55:40];
        rsp_data  <= pkt[39:8];
        rsp_ready <= 1'b1;
      end else if (pkt_done) begin
        bad_sum <= 1'b1;
      end
    end
  end

  // read data valid in the cycle after the strobe only
  always_ff @(posedge clock) begin
    if (srst || !reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else begin
      case (reg_addr)
        REG_REQ_HEAD: reg_rdata <= {16'h0000, req_head};
        REG_REQ_DATA: reg_rdata <= req_data;
        REG_STAT:     reg_rdata <= {29'h00000000, bad_sum, rsp_ready, busy};
        REG_RSP_HEAD: reg_rdata <= {16'h0000, rsp_head};
        REG_RSP_DATA: reg_rdata <= rsp_data;
        default:      reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // transmitter of the request packet
  assign busy = tx_cnt != 16'h0000 || tx_bitn != 4'h0 || tx_left != 4'h0;
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_cnt  <= 16'h0000;
      tx_bitn <= 4'h0;
      tx_left <= 4'h0;
      tx_fr   <= 10'h3FF;
      tx_pkt  <= 64'h0000000000000000;
      tx_line <= 1'b1;
    end else if (tx_cnt != 16'h0000) begin
      tx_cnt <= tx_cnt - 16'h0001;
    end else if (tx_bitn != 4'h0) begin
      tx_line <= tx_fr[0];
      tx_fr   <= {1'b1, tx_fr[9:1]};
      tx_bitn <= tx_bitn - 4'h1;
      tx_cnt  <= BIT_CYCLES - 16'h0001;
    end else if (tx_left != 4'h0) begin
      tx_fr   <= {1'b1, tx_pkt[63:56], 1'b0};
      tx_pkt  <= {tx_pkt[55:0], 8'h00};
      tx_left <= tx_left - 4'h1;
      tx_bitn <= FRAME_BITS;
    end else if (send) begin
      tx_pkt  <= rsp_seal({SOH, req_head, req_data});
      tx_left <= PKT_LEN;
    end
  end
  assign link.req_line = tx_line;
endmodule // rsp_host

//--- tb/rsp_link_properties.sv
// link checker: idle level and bit timing of both serial lines
// assumes one clock, srst synchronous active high
`timescale 1ns/1ns
module rsp_link_properties #(
  parameter logic [15:0] BIT_CYCLES = 16'h0010
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic req_line,
  input wire logic rsp_line
);
  localparam int BCM = int'(BIT_CYCLES) - 1;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // a low run is never shorter than eight cycles, half of a default 16-cycle bit
  sequence s_req_low; !req_line [*8]; endsequence
  sequence s_rsp_low; !rsp_line [*8]; endsequence
  property p_rst_idle; $fell(srst) |-> req_line && rsp_line; endproperty
  property p_req_low; $fell(req_line) |-> s_req_low; endproperty
  property p_rsp_low; $fell(rsp_line) |-> s_rsp_low; endproperty
  property p_req_bit0; $fell(req_line) |-> ##BCM !req_line; endproperty
  property p_req_bit1; $rose(req_line) |-> ##BCM req_line; endproperty
  property p_rsp_bit0; $fell(rsp_line) |-> ##BCM !rsp_line; endproperty
  property p_rsp_bit1; $rose(rsp_line) |-> ##BCM rsp_line; endproperty
  // reply only after the request, so replies never overlap it
  property p_half_duplex; !req_line |-> rsp_line; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("line not idle after reset");
  a_req_low: assert property (p_req_low) else $error("request low run short");
  a_rsp_low: assert property (p_rsp_low) else $error("reply low run short");
  a_req_bit0: assert property (p_req_bit0) else $error("request zero bit short");
  a_req_bit1: assert property (p_req_bit1) else $error("request one bit short");
  a_rsp_bit0: assert property (p_rsp_bit0) else $error("reply zero bit short");
  a_rsp_bit1: assert property (p_rsp_bit1) else $error("reply one bit short");
  a_half_duplex: assert property (p_half_duplex) else $error("reply during request");
endmodule // rsp_link_properties

//--- tb/tb_relay_status_and_serial_packet_port.sv
// bench: host and relay ends joined by one link, driven from both user sides
// assumes 100 MHz clock, short bit time of 16 cycles
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_relay_status_and_serial_packet_port;
  import rsp_pkg::*;
  logic clock = 0, srst = 1, stop_input = 0, reset_input = 0, run_one_input = 0, run_two_input = 0;
  logic aux_input_one = 0, aux_input_two = 0, network_control_input = 0, login_above_user = 0;
  logic fault_active = 0, warning_active = 0, motor_hot = 0, net_active = 0, net_run_one = 0;
  logic net_run_two = 0, net_stop = 0, expl_valid = 0, reg_wr = 0, reg_rd = 0, ok;
  logic run_one_cmd, run_two_cmd, status_change, expl_rsp_valid;
  logic [3:0]  fault_cause = 0;
  logic [7:0]  node_switch = 0, cooldown_time = 0, expl_service = 0, expl_class = 0, expl_instance = 0;
  logic [7:0]  expl_attribute = 0, reg_addr = 0, expl_rsp_service, response_low_byte, response_high_byte;
  logic [15:0] status_word, switch_word, cooldown_word;
  logic [31:0] reg_wdata = 0, reg_rdata;
  int          n_mismatch = 0, check_count = 0, cyc = 0;
  rsp_link_if link();
  rsp_device #(.BIT_CYCLES(16'h0010)) rsp_device_i (.*);
  rsp_host #(.BIT_CYCLES(16'h0010)) rsp_host_i (.*);
  rsp_link_properties #(.BIT_CYCLES(16'h0010)) rsp_link_properties_i (.clock(clock), .srst(srst),
    .req_line(link.req_line), .rsp_line(link.rsp_line));
  always #5 clock = ~clock;
  // hang guard, far above one round trip of about 2600 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one register cycle; read data lands right after the taking edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock); reg_wr <= w; reg_rd <= !w; reg_addr <= a; reg_wdata <= d;
    @(posedge clock); reg_wr <= 0; reg_rd <= 0;
    #1;
  endtask
  task expl(input logic [7:0] c, input logic [23:0] e);
    @(posedge clock); expl_valid <= 1; expl_service <= 8'h0E; expl_class <= c; expl_instance <= 8'h01;
    expl_attribute <= 8'h34;
    @(posedge clock); expl_valid <= 0;
    #1 `CHK({expl_rsp_valid, expl_rsp_service, response_low_byte, response_high_byte}, {1'b1, e})
  endtask
  task t_explicit;
    @(posedge clock); node_switch <= 8'h5A; reset_input <= 1; aux_input_one <= 1; aux_input_two <= 1;
    repeat (8) @(posedge clock);
    expl(8'h64, 24'h8E325A);
    expl(8'h65, 24'h940000);
    `CHK(switch_word, 16'h5A32)
    @(posedge clock); reset_input <= 0;
  endtask
  task t_status;
    @(posedge clock); motor_hot <= 1; cooldown_time <= 8'hC8;
    @(posedge clock); fault_active <= 1;
    for (int c = 0; c < 12; c++) begin
      @(posedge clock); fault_cause <= 4'(c);
      @(posedge clock);
      #1 `CHK(status_change, 1'b1)
      @(posedge clock);
      #1 `CHK({status_word[15], status_word[11:8], status_word[0], status_change}, {1'b1, 4'(c), 2'b10})
    end
    `CHK(cooldown_word, 16'h0063)
    @(posedge clock); fault_active <= 0;
  endtask
  task t_runs;
    @(posedge clock); network_control_input <= 1; run_one_input <= 1;
    repeat (8) @(posedge clock);
    #1 `CHK({run_one_cmd, run_two_cmd, status_word[5]}, 3'b001)
    @(posedge clock); net_run_one <= 1;
    @(posedge clock); net_run_one <= 0; stop_input <= 1;
    #1 `CHK(run_one_cmd, 1'b1)
    repeat (8) @(posedge clock);
    #1 `CHK(run_one_cmd, 1'b0)
    // the stop pin needs its sync delay to clear before a new run is obeyed
    @(posedge clock); stop_input <= 0;
    repeat (8) @(posedge clock); net_run_one <= 1;
    @(posedge clock); net_run_one <= 0;
    #1 `CHK({run_one_cmd, run_two_cmd}, 2'b10)
    @(posedge clock); network_control_input <= 0;
    repeat (8) @(posedge clock);
    #1 `CHK({run_one_cmd, status_word[11:8]}, 5'h0A)
  endtask
  task t_serial;
    bus(1, 8'h00, 32'h0E38);
    bus(1, 8'h08, 32'h1);
    ok = 0;
    for (int i = 0; i < 40 && !ok; i++) begin
      repeat (100) @(posedge clock);
      bus(0, 8'h0C, 0);
      ok = reg_rdata[1];
    end
    `CHK(reg_rdata[2:0], 3'b010)
    bus(0, 8'h10, 0); `CHK(reg_rdata, 32'h00008E38)
    bus(0, 8'h14, 0); `CHK(reg_rdata, 32'h00000063)
    bus(0, 8'h40, 0); `CHK(reg_rdata, 32'h0)
  endtask
  initial begin
    repeat (10) @(posedge clock);
    srst <= 0;
    t_explicit();
    t_status();
    t_runs();
    t_serial();
    print_verdict();
  end
endmodule // tb_relay_status_and_serial_packet_port
